// ==== verilog/tla_core.sv ====
// conversion sequencing, limit comparison and alert output logic
//
// Behaviour
// - a cycle converts local, then remote; each reading updates its result and status as it ends; 31.25 ms
// - conversion rate adds idle delay between cycles, never changes cycle length
// - critical output low from a remote reading above critical limit until one at or below limit minus hysteresis, no latching
// - local vs local high; remote vs remote high, low and critical
// - each finished reading is checked and sets its status bit when out of limits
// - mask clear, interrupt mode: any status bit but busy and open pulls alert low
// - mask zero enables alerts; mask set blocks alert in every mode
// - standby bit stops continuous conversions
// - in standby a config bit decides whether fan pwm keeps running
// - comparator mode: alert releases by itself once condition ends
// - comparator-mode bit set selects comparator; clear selects interrupt, reset clear
// - interrupt mode status read with flags set sets the mask bit
// - status bits other than busy clear only on status read; reassert at next conversion end
// - interrupt mode status read clears status and releases alert
// - hysteresis register sets the hysteresis of the comparator-mode and critical comparisons; status flags compare without it
// - remote values are 11-bit left justified in 16-bit high/low words
// - local reading and local limit are 8-bit registers
// - signed offset is added to the remote reading
// - remote values two's complement, lsb 0.125 degrees
// - local values two's complement bytes, lsb 1 degree
// - interrupt mode: after alert-response address sent, release alert and set mask
`timescale 1ns/100ps
module tla_core #(
	parameter int unsigned CONV_CYC = tla_pkg::CONV_CYCLES,
	parameter int unsigned RATE_CYC = tla_pkg::RATE_UNIT_CYC
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic [7:0]  i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	output logic [1:0]       o_bresp,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	input  wire logic [7:0]  i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	input  wire logic [7:0]  i_local_adc,
	input  wire logic [15:0] i_remote_adc,
	input  wire logic        i_diode_open,
	input  wire logic        i_ara_sent,
	output logic             o_alert_oe,
	output logic             o_crit_oe,
	output logic             o_pwm_run,
	output logic             o_standby,
	output logic             o_busy
);
	import tla_pkg::*;

	// ------------------------------------------------------------
	// registers and nets
	// ------------------------------------------------------------
	logic [7:0]     local_temp_reading_r;
	logic [15:0]    remote_temp_reading_r;
	logic [7:0]     local_high_limit_r;
	logic [15:0]    remote_high_limit_r;
	logic [15:0]    remote_low_limit_r;
	logic [15:0]    remote_critical_limit_r;
	logic [7:0]     hysteresis_value_r;
	logic [7:0]     remote_offset_high_byte_r;
	logic [7:0]     remote_offset_low_byte_r;
	logic [7:0]     config_r;
	logic           cmp_mode_r;
	logic [7:0]     rate_r;
	logic [7:0]     status_r;
	tla_conv_t      state_r;
	logic [CNT_W-1:0] cnt_r;
	logic [7:0]     rate_cnt_r;
	logic           eval_local;
	logic           eval_remote;
	logic           trip_lh;
	logic           trip_rh;
	logic           trip_rl;
	logic           trip_rc;
	logic           open_s1_r;
	logic           open_s2_r;
	logic           ara_s1_r;
	logic           ara_s2_r;
	logic           ara_d_r;
	logic           ara_pulse;
	logic           wr;
	logic [7:0]     wr_addr;
	logic [31:0]    wr_data;
	logic [3:0]     wr_strb;
	logic           rd;
	logic [7:0]     rd_addr;
	logic [31:0]    rd_data;
	logic           rd_ok;
	logic           wr_ok;
	logic           status_rd;
	logic [15:0]    remote_corr;
	logic [7:0]     status_set;

	// returns true for any mapped register address
	function automatic logic addr_mapped(input logic [7:0] a);
		case (a)
			A_LOCAL_TEMP, A_REMOTE_TEMP, A_LOCAL_HIGH, A_REMOTE_HIGH, A_REMOTE_LOW,
			A_REMOTE_CRIT, A_HYST, A_OFFSET, A_CONFIG, A_MODE, A_RATE, A_STATUS,
			A_ARA_DONE: addr_mapped = 1'b1;
			default:    addr_mapped = 1'b0;
		endcase
	endfunction

	// ------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------
	tla_axil u_axil (
		.i_clk     (i_clk),
		.i_rst     (i_rst),
		.i_awaddr  (i_awaddr),
		.i_awvalid (i_awvalid),
		.o_awready (o_awready),
		.i_wdata   (i_wdata),
		.i_wstrb   (i_wstrb),
		.i_wvalid  (i_wvalid),
		.o_wready  (o_wready),
		.o_bresp   (o_bresp),
		.o_bvalid  (o_bvalid),
		.i_bready  (i_bready),
		.i_araddr  (i_araddr),
		.i_arvalid (i_arvalid),
		.o_arready (o_arready),
		.o_rdata   (o_rdata),
		.o_rresp   (o_rresp),
		.o_rvalid  (o_rvalid),
		.i_rready  (i_rready),
		.o_wr      (wr),
		.o_wr_addr (wr_addr),
		.o_wr_data (wr_data),
		.o_wr_strb (wr_strb),
		.i_wr_ok   (wr_ok),
		.o_rd      (rd),
		.o_rd_addr (rd_addr),
		.i_rd_data (rd_data),
		.i_rd_ok   (rd_ok)
	);

	assign wr_ok     = addr_mapped(wr_addr);
	assign rd_ok     = addr_mapped(rd_addr);
	assign status_rd = rd && (rd_addr == A_STATUS);

	// read mux; narrow registers sit in the low bits
	always_comb begin
		case (rd_addr)
			A_LOCAL_TEMP:  rd_data = {24'h000000, local_temp_reading_r};
			A_REMOTE_TEMP: rd_data = {16'h0000, remote_temp_reading_r};
			A_LOCAL_HIGH:  rd_data = {24'h000000, local_high_limit_r};
			A_REMOTE_HIGH: rd_data = {16'h0000, remote_high_limit_r};
			A_REMOTE_LOW:  rd_data = {16'h0000, remote_low_limit_r};
			A_REMOTE_CRIT: rd_data = {16'h0000, remote_critical_limit_r};
			A_HYST:        rd_data = {24'h000000, hysteresis_value_r};
			A_OFFSET:      rd_data = {16'h0000, remote_offset_high_byte_r,
			                          remote_offset_low_byte_r};
			A_CONFIG:      rd_data = {24'h000000, config_r};
			A_MODE:        rd_data = {31'h00000000, cmp_mode_r};
			A_RATE:        rd_data = {24'h000000, rate_r};
			A_STATUS:      rd_data = {24'h000000, status_r};
			default:       rd_data = 32'h0000_0000;
		endcase
	end

	// ------------------------------------------------------------
	// software written limits, offset and rate
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			local_high_limit_r        <= RST_LOCAL_HIGH;
			remote_high_limit_r       <= RST_REMOTE_HIGH;
			remote_low_limit_r        <= RST_REMOTE_LOW;
			remote_critical_limit_r   <= RST_REMOTE_CRIT;
			hysteresis_value_r        <= RST_HYST;
			remote_offset_high_byte_r <= 8'h00;
			remote_offset_low_byte_r  <= 8'h00;
			rate_r                    <= RST_RATE;
			cmp_mode_r                <= 1'b0; // interrupt mode after reset
		end else if (wr) begin
			case (wr_addr)
				A_LOCAL_HIGH:  if (wr_strb[0]) local_high_limit_r <= wr_data[7:0];
				A_REMOTE_HIGH: begin
					if (wr_strb[1]) remote_high_limit_r[15:8] <= wr_data[15:8];
					if (wr_strb[0]) remote_high_limit_r[7:5]  <= wr_data[7:5];
				end
				A_REMOTE_LOW:  begin
					if (wr_strb[1]) remote_low_limit_r[15:8] <= wr_data[15:8];
					if (wr_strb[0]) remote_low_limit_r[7:5]  <= wr_data[7:5];
				end
				A_REMOTE_CRIT: begin
					if (wr_strb[1]) remote_critical_limit_r[15:8] <= wr_data[15:8];
					if (wr_strb[0]) remote_critical_limit_r[7:5]  <= wr_data[7:5];
				end
				A_HYST:        if (wr_strb[0]) hysteresis_value_r <= wr_data[7:0];
				A_OFFSET:      begin
					if (wr_strb[1]) remote_offset_high_byte_r <= wr_data[15:8];
					if (wr_strb[0]) remote_offset_low_byte_r  <= {wr_data[7:5], 5'h00};
				end
				A_MODE:        if (wr_strb[0]) cmp_mode_r <= wr_data[MODE_CMP_BIT];
				A_RATE:        if (wr_strb[0]) rate_r <= wr_data[7:0];
				default:       ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// configuration: mask, standby, pwm disable in standby
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			config_r <= 8'h00;
		end else begin
			if (wr && wr_addr == A_CONFIG && wr_strb[0])
				config_r <= wr_data[7:0]; // mask zero enables alerts
			// hardware set of the mask wins over a software clear
			if ((status_rd && !cmp_mode_r && |(status_r & ST_ALERT_MASK))
			    || (ara_pulse && !cmp_mode_r))
				config_r[CFG_MASK_BIT] <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// pin synchronisers, alert-response completion pulse
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			open_s1_r <= 1'b0;
			open_s2_r <= 1'b0;
			ara_s1_r  <= 1'b0;
			ara_s2_r  <= 1'b0;
			ara_d_r   <= 1'b0;
		end else begin
			open_s1_r <= i_diode_open;
			open_s2_r <= open_s1_r;
			ara_s1_r  <= i_ara_sent;
			ara_s2_r  <= ara_s1_r;
			ara_d_r   <= ara_s2_r;
		end
	end
	assign ara_pulse = (ara_s2_r && !ara_d_r) || (wr && wr_addr == A_ARA_DONE);

	// ------------------------------------------------------------
	// conversion sequencer
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_r    <= TLA_IDLE;
			cnt_r      <= '0;
			rate_cnt_r <= 8'h00;
		end else begin
			case (state_r)
				TLA_IDLE: begin
					if (!config_r[CFG_STBY_BIT]) begin // standby halts conversions
						state_r <= TLA_LOCAL;
						cnt_r   <= '0;
					end
				end
				TLA_LOCAL: begin // local first, remote after
					cnt_r <= cnt_r + 1'b1;
					if (cnt_r == CNT_W'(CONV_CYC / LOCAL_PHASE_DIV - 1))
						state_r <= TLA_REMOTE;
				end
				TLA_REMOTE: begin
					cnt_r <= cnt_r + 1'b1;
					if (cnt_r == CNT_W'(CONV_CYC - 1)) begin // fixed length
						state_r    <= TLA_DELAY;
						cnt_r      <= '0;
						rate_cnt_r <= rate_r;
					end
				end
				TLA_DELAY: begin // idle gap set by the rate register
					if (rate_cnt_r == 8'h00) begin
						state_r <= TLA_IDLE;
					end else if (cnt_r == CNT_W'(RATE_CYC - 1)) begin
						cnt_r      <= '0;
						rate_cnt_r <= rate_cnt_r - 8'h01;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				default: state_r <= TLA_IDLE;
			endcase
		end
	end

	assign eval_local  = (state_r == TLA_LOCAL) && (cnt_r == CNT_W'(CONV_CYC / LOCAL_PHASE_DIV - 1));
	assign eval_remote = (state_r == TLA_REMOTE) && (cnt_r == CNT_W'(CONV_CYC - 1));
	assign remote_corr = {remote_offset_high_byte_r, remote_offset_low_byte_r}
	                     + {i_remote_adc[15:5], 5'h00};

	// result registers, updated at the end of each reading
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			local_temp_reading_r  <= 8'h00;
			remote_temp_reading_r <= 16'h0000;
		end else begin
			if (eval_local)
				local_temp_reading_r <= i_local_adc;
			if (eval_remote)
				remote_temp_reading_r <= remote_corr;
		end
	end

	// ------------------------------------------------------------
	// limit comparators
	// ------------------------------------------------------------
	tla_cmp #(.W(8)) u_cmp_lh (
		.i_clk(i_clk), .i_rst(i_rst), .i_eval(eval_local), .i_value(i_local_adc),
		.i_limit(local_high_limit_r), .i_hyst(hysteresis_value_r), .i_low(1'b0),
		.o_trip(trip_lh));
	tla_cmp #(.W(16)) u_cmp_rh (
		.i_clk(i_clk), .i_rst(i_rst), .i_eval(eval_remote), .i_value(remote_corr),
		.i_limit(remote_high_limit_r), .i_hyst({hysteresis_value_r, 8'h00}), // whole degrees
		.i_low(1'b0), .o_trip(trip_rh));
	tla_cmp #(.W(16)) u_cmp_rl (
		.i_clk(i_clk), .i_rst(i_rst), .i_eval(eval_remote), .i_value(remote_corr),
		.i_limit(remote_low_limit_r), .i_hyst({hysteresis_value_r, 8'h00}),
		.i_low(1'b1), .o_trip(trip_rl));
	tla_cmp #(.W(16)) u_cmp_rc (
		.i_clk(i_clk), .i_rst(i_rst), .i_eval(eval_remote), .i_value(remote_corr),
		.i_limit(remote_critical_limit_r), .i_hyst({hysteresis_value_r, 8'h00}),
		.i_low(1'b0), .o_trip(trip_rc));

	// flags raised by the reading that completes this cycle
	always_comb begin
		status_set = 8'h00;
		status_set[ST_LHIGH_BIT] = eval_local && ($signed(i_local_adc) > $signed(local_high_limit_r));
		status_set[ST_RHIGH_BIT] = eval_remote && ($signed(remote_corr) > $signed(remote_high_limit_r));
		status_set[ST_RLOW_BIT]  = eval_remote && ($signed(remote_corr) < $signed(remote_low_limit_r));
		status_set[ST_RCRIT_BIT] = eval_remote &&
		                           ($signed(remote_corr) > $signed(remote_critical_limit_r));
		status_set[ST_OPEN_BIT]  = eval_remote && open_s2_r;
	end

	// sticky status: cleared by a read, a new event in the same cycle wins
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			status_r <= 8'h00;
		end else begin
			status_r <= (status_rd ? 8'h00 : status_r) | status_set;
			status_r[ST_BUSY_BIT] <= (state_r == TLA_LOCAL) || (state_r == TLA_REMOTE);
		end
	end

	// ------------------------------------------------------------
	// output pins, all from flip-flops
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_alert_oe <= 1'b0;
			o_crit_oe  <= 1'b0;
			o_pwm_run  <= 1'b1;
			o_standby  <= 1'b0;
			o_busy     <= 1'b0;
		end else begin
			if (config_r[CFG_MASK_BIT])
				o_alert_oe <= 1'b0; // mask blocks every mode
			else if (cmp_mode_r)
				o_alert_oe <= trip_lh | trip_rh | trip_rl | trip_rc;
			else
				o_alert_oe <= |(status_r & ST_ALERT_MASK) && !status_rd;
			o_crit_oe  <= trip_rc; // non-latching critical output
			o_pwm_run  <= !(config_r[CFG_STBY_BIT] && config_r[CFG_PWMDIS_BIT]);
			o_standby  <= config_r[CFG_STBY_BIT];
			o_busy     <= status_r[ST_BUSY_BIT];
		end
	end
endmodule // tla_core

// ==== pkg/tla_pkg.sv ====
// constants, register map and types of the temperature limit alert block
package tla_pkg;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 250_000_000;
	localparam int unsigned CONV_TIME_US    = 31_250; // one conversion cycle, 31.25 ms
	localparam int unsigned CONV_CYCLES     = (CLK_HZ / 1_000_000) * CONV_TIME_US;
	localparam int unsigned LOCAL_PHASE_DIV = 2;      // local phase takes half the cycle
	localparam int unsigned RATE_UNIT_US    = 31_250; // idle delay per rate step
	localparam int unsigned RATE_UNIT_CYC   = (CLK_HZ / 1_000_000) * RATE_UNIT_US;
	localparam int unsigned CNT_W           = 32;

	// ------------------------------------------------------------
	// register byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] A_LOCAL_TEMP   = 8'h00;
	localparam logic [7:0] A_REMOTE_TEMP  = 8'h04;
	localparam logic [7:0] A_LOCAL_HIGH   = 8'h08;
	localparam logic [7:0] A_REMOTE_HIGH  = 8'h0c;
	localparam logic [7:0] A_REMOTE_LOW   = 8'h10;
	localparam logic [7:0] A_REMOTE_CRIT  = 8'h14;
	localparam logic [7:0] A_HYST         = 8'h18;
	localparam logic [7:0] A_OFFSET       = 8'h1c;
	localparam logic [7:0] A_CONFIG       = 8'h20;
	localparam logic [7:0] A_MODE         = 8'h24;
	localparam logic [7:0] A_RATE         = 8'h28;
	localparam logic [7:0] A_STATUS       = 8'h2c;
	localparam logic [7:0] A_ARA_DONE     = 8'h30;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int unsigned CFG_MASK_BIT    = 7;
	localparam int unsigned CFG_STBY_BIT    = 6;
	localparam int unsigned CFG_PWMDIS_BIT  = 5;
	localparam int unsigned MODE_CMP_BIT    = 0;
	localparam int unsigned ST_BUSY_BIT     = 7;
	localparam int unsigned ST_LHIGH_BIT    = 6;
	localparam int unsigned ST_RHIGH_BIT    = 4;
	localparam int unsigned ST_RLOW_BIT     = 3;
	localparam int unsigned ST_OPEN_BIT     = 2;
	localparam int unsigned ST_RCRIT_BIT    = 1;
	localparam logic [7:0]  ST_ALERT_MASK   = 8'h7a; // all flags except busy and open

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0]  RST_LOCAL_HIGH  = 8'h46;
	localparam logic [15:0] RST_REMOTE_HIGH = 16'h4600;
	localparam logic [15:0] RST_REMOTE_LOW  = 16'h0000;
	localparam logic [15:0] RST_REMOTE_CRIT = 16'h5500;
	localparam logic [7:0]  RST_HYST        = 8'h0a;
	localparam logic [7:0]  RST_RATE        = 8'h00;

	// ------------------------------------------------------------
	// axi responses
	// ------------------------------------------------------------
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// conversion sequencer states
	typedef enum logic [3:0] {
		TLA_IDLE   = 4'h1,
		TLA_LOCAL  = 4'h2,
		TLA_REMOTE = 4'h4,
		TLA_DELAY  = 4'h8
	} tla_conv_t;
endpackage

// ==== verilog/tla_cmp.sv ====
// signed limit comparator with hysteresis
`timescale 1ns/100ps
module tla_cmp #(
	parameter int unsigned W = 16
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic         i_eval,
	input  wire logic [W-1:0] i_value,
	input  wire logic [W-1:0] i_limit,
	input  wire logic [W-1:0] i_hyst,
	input  wire logic         i_low,
	output logic              o_trip
);
	logic signed [W:0] val_s;
	logic signed [W:0] lim_s;
	logic signed [W:0] rel_s;
	logic              trip_nxt;

	// strict compare; once tripped, release only at or below limit minus hysteresis (high) or at or above limit plus hysteresis (low)
	always_comb begin
		val_s = {i_value[W-1], i_value};
		lim_s = {i_limit[W-1], i_limit};
		if (i_low) begin
			rel_s    = lim_s + $signed({1'b0, i_hyst});
			trip_nxt = o_trip ? (val_s < rel_s) : (val_s < lim_s);
		end else begin
			rel_s    = lim_s - $signed({1'b0, i_hyst});
			trip_nxt = o_trip ? (val_s > rel_s) : (val_s > lim_s);
		end
	end

	// condition is updated only when a reading completes
	always_ff @(posedge i_clk) begin
		if (i_rst)
			o_trip <= 1'b0;
		else if (i_eval)
			o_trip <= trip_nxt;
	end
endmodule // tla_cmp

// ==== verilog/tla_axil.sv ====
// axi4-lite slave front end, one word registers
`timescale 1ns/100ps
module tla_axil (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic [7:0]  i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	output logic [1:0]       o_bresp,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	input  wire logic [7:0]  i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	output logic             o_wr,
	output logic [7:0]       o_wr_addr,
	output logic [31:0]      o_wr_data,
	output logic [3:0]       o_wr_strb,
	input  wire logic        i_wr_ok,
	output logic             o_rd,
	output logic [7:0]       o_rd_addr,
	input  wire logic [31:0] i_rd_data,
	input  wire logic        i_rd_ok
);
	import tla_pkg::*;
	logic aw_held_r;
	logic w_held_r;

	// capture write address and data in either order
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_awready <= 1'b1;
			o_wready  <= 1'b1;
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			o_wr_addr <= 8'h00;
			o_wr_data <= 32'h0000_0000;
			o_wr_strb <= 4'h0;
			o_wr      <= 1'b0;
		end else begin
			o_wr <= 1'b0;
			if (i_awvalid && o_awready) begin
				o_wr_addr <= i_awaddr;
				aw_held_r <= 1'b1;
				o_awready <= 1'b0;
			end
			if (i_wvalid && o_wready) begin
				o_wr_data <= i_wdata;
				o_wr_strb <= i_wstrb;
				w_held_r  <= 1'b1;
				o_wready  <= 1'b0;
			end
			if (aw_held_r && w_held_r && !o_wr && !o_bvalid) begin
				o_wr      <= 1'b1;
				aw_held_r <= 1'b0;
				w_held_r  <= 1'b0;
			end
			if (o_bvalid && i_bready) begin
				o_awready <= 1'b1;
				o_wready  <= 1'b1;
			end
		end
	end

	// write response raised on the same edge as the register update
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_bvalid <= 1'b0;
			o_bresp  <= RESP_OKAY;
		end else if (o_wr) begin
			o_bvalid <= 1'b1;
			o_bresp  <= i_wr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (i_bready) begin
			o_bvalid <= 1'b0;
		end
	end

	// read channel, read strobe goes to the register file
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_arready <= 1'b1;
			o_rd      <= 1'b0;
			o_rd_addr <= 8'h00;
			o_rvalid  <= 1'b0;
			o_rdata   <= 32'h0000_0000;
			o_rresp   <= RESP_OKAY;
		end else begin
			o_rd <= 1'b0;
			if (i_arvalid && o_arready) begin
				o_rd_addr <= i_araddr;
				o_rd      <= 1'b1;
				o_arready <= 1'b0;
			end
			if (o_rd) begin
				o_rvalid <= 1'b1;
				o_rdata  <= i_rd_data;
				o_rresp  <= i_rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (o_rvalid && i_rready) begin
				o_rvalid  <= 1'b0;
				o_arready <= 1'b1;
			end
		end
	end
endmodule // tla_axil

// ==== tb/tla_core_asserts.sv ====
// port assertions for the temperature limit alert core
`timescale 1ns/100ps
module tla_core_asserts (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_awvalid,
	input wire logic i_wvalid,
	input wire logic i_arvalid,
	input wire logic i_bready,
	input wire logic i_rready,
	input wire logic o_awready,
	input wire logic o_wready,
	input wire logic o_arready,
	input wire logic o_bvalid,
	input wire logic o_rvalid,
	input wire logic o_pwm_run,
	input wire logic o_standby
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// bus handshake and fan gating relations
	property p_bhold; o_bvalid && !i_bready |=> o_bvalid; endproperty
	a_bhold: assert property (p_bhold) else $error("write answer dropped early");
	property p_rhold; o_rvalid && !i_rready |=> o_rvalid; endproperty
	a_rhold: assert property (p_rhold) else $error("read answer dropped early");
	property p_rlat; i_arvalid && o_arready |-> ##[2:3] o_rvalid; endproperty
	a_rlat: assert property (p_rlat) else $error("read answer late");
	property p_wlat; i_awvalid && o_awready && i_wvalid && o_wready |-> ##[2:4] o_bvalid; endproperty
	a_wlat: assert property (p_wlat) else $error("write answer late");
	property p_arbusy; o_rvalid |-> !o_arready; endproperty
	a_arbusy: assert property (p_arbusy) else $error("read accepted while answering");
	property p_awbusy; o_bvalid |-> !o_awready && !o_wready; endproperty
	a_awbusy: assert property (p_awbusy) else $error("write accepted while answering");
	property p_bdone; $fell(o_bvalid) |-> $past(i_bready); endproperty
	a_bdone: assert property (p_bdone) else $error("write answer fell without ready");
	property p_pwm; !o_pwm_run |-> o_standby; endproperty
	a_pwm: assert property (p_pwm) else $error("fan stopped outside standby");
endmodule // tla_core_asserts

// ==== tb/tla_host.sv ====
// host that answers a low alert line with an alert response
`timescale 1ns/100ps
module tla_host (
	input  wire logic i_clk,
	input  wire logic i_en,
	input  wire logic i_alert_oe,
	output logic      o_ara_sent
);
	logic [3:0] cnt_r;
	// address goes out a while after alert is seen, held while the host is enabled
	always_ff @(posedge i_clk) begin
		cnt_r <= (i_en && i_alert_oe && cnt_r != 4'hf) ? cnt_r + 4'h1 : (i_en ? cnt_r : 4'h0);
		o_ara_sent <= i_en && cnt_r == 4'hf;
	end
endmodule // tla_host

// ==== tb/tla_core_tb.sv ====
// self-checking bench for the temperature limit alert core
`timescale 1ns/100ps
module tla_core_tb;
	import tla_pkg::*;
	logic        i_clk = 0, i_rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, ara_en = 0;
	logic [7:0]  awa = 0, ara_a = 0, ladc = 0;
	logic [15:0] radc = 0;
	logic [31:0] wd = 0, rdata, rdo;
	logic [1:0]  rresp, rrs, brs, bresp;
	logic        dop = 0;
	int          n, n0;
	localparam int CONV = 100, STEP = 20; // shortened conversion and rate step
	logic        awr, wr_y, bv, arr, rv, alert, crit, pwm, sby, busy, ara;
	int          failures = 0, tests_run = 0, cycles = 0;
	logic [7:0]  ra [5] = '{A_LOCAL_HIGH, A_REMOTE_HIGH, A_REMOTE_CRIT, A_HYST, A_MODE};
	logic [15:0] rvx [5] = '{RST_LOCAL_HIGH, RST_REMOTE_HIGH, RST_REMOTE_CRIT, RST_HYST, 0};
	always #2 i_clk = ~i_clk;
	tla_core #(.CONV_CYC(CONV), .RATE_CYC(STEP)) i_tla_core (.i_clk(i_clk), .i_rst(i_rst),
		.i_awaddr(awa), .i_awvalid(awv), .o_awready(awr), .i_wdata(wd), .i_wstrb(4'hf),
		.i_wvalid(wv), .o_wready(wr_y), .o_bresp(brs), .o_bvalid(bv), .i_bready(bry),
		.i_araddr(ara_a), .i_arvalid(arv), .o_arready(arr), .o_rdata(rdo), .o_rresp(rrs),
		.o_rvalid(rv), .i_rready(rry), .i_local_adc(ladc), .i_remote_adc(radc),
		.i_diode_open(dop), .i_ara_sent(ara), .o_alert_oe(alert), .o_crit_oe(crit),
		.o_pwm_run(pwm), .o_standby(sby), .o_busy(busy));
	tla_host i_tla_host (.i_clk(i_clk), .i_en(ara_en), .i_alert_oe(alert), .o_ara_sent(ara));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	// counts the cycles of the next full busy pulse at the given level
	task busy_len(input logic lvl, output int len);
		while (busy === lvl) @(posedge i_clk);
		while (busy !== lvl) @(posedge i_clk);
		len = 0;
		while (busy === lvl) begin
			len++;
			@(posedge i_clk);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		awa <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		bry <= 1;
		do begin
			@(posedge i_clk);
			if (awv && awr) awv <= 0;
			if (wv && wr_y) wv <= 0;
		end while (!bv);
		bry <= 0;
		bresp = brs;
	endtask
	task rd(input logic [7:0] a);
		@(posedge i_clk);
		ara_a <= a;
		arv <= 1;
		rry <= 1;
		do begin
			@(posedge i_clk);
			if (arv && arr) arv <= 0;
		end while (!rv);
		rry <= 0;
		rdata = rdo;
		rresp = rrs;
	endtask
	task print_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// hang guard
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			print_verdict;
		end
	end
	// reset values, equal limits, interrupt flow, alert response, critical, comparator, standby
	initial begin
		wt(2);
		i_rst <= 0;
		for (int k = 0; k < 5; k++) begin
			rd(ra[k]);
			chk(rdata, rvx[k]);
		end
		rd(8'h80);
		chk(rresp, RESP_SLVERR);
		wr(8'h80, 0);
		chk(bresp, RESP_SLVERR);
		radc <= 16'h4600;
		ladc <= 8'h46;
		dop <= 1;
		wt(200);
		chk(alert, 0);
		rd(A_STATUS);
		chk(rdata & ST_ALERT_MASK, 0);
		chk(rdata[ST_OPEN_BIT], 1);
		dop <= 0;
		rd(A_REMOTE_TEMP);
		chk(rdata, 32'h4600);
		rd(A_LOCAL_TEMP);
		chk(rdata, 32'h46);
		radc <= 16'h4700;
		ladc <= 8'h47;
		wt(200);
		chk(alert, 1);
		rd(A_STATUS);
		chk(rdata & ST_ALERT_MASK, 8'h50);
		wt(2);
		chk(alert, 0);
		rd(A_CONFIG);
		chk(rdata[7], 1);
		wt(200);
		chk(alert, 0);
		wr(A_CONFIG, 0);
		wt(200);
		chk(alert, 1);
		ara_en <= 1;
		wt(40);
		chk(alert, 0);
		rd(A_CONFIG);
		chk(rdata[7], 1);
		ara_en <= 0;
		radc <= 16'h5600;
		wt(200);
		chk(crit, 1);
		radc <= 0;
		wt(200);
		chk(crit, 0);
		wr(A_MODE, 1);
		wr(A_CONFIG, 0);
		rd(A_STATUS);
		ladc <= 0;
		radc <= 16'h4700;
		wt(200);
		chk(alert, 1);
		wr(A_CONFIG, 32'h80);
		wt(4);
		chk(alert, 0);
		wr(A_CONFIG, 0);
		radc <= 16'h4000;
		wt(200);
		chk(alert, 1);
		radc <= 0;
		wt(200);
		chk(alert, 0);
		wr(A_OFFSET, 32'hff00);
		busy_len(1, n);
		chk(n, CONV);
		rd(A_REMOTE_TEMP);
		chk(rdata, 32'hff00);
		chk(alert, 1);
		busy_len(0, n0);
		wr(A_RATE, 2);
		busy_len(0, n);
		chk(n - n0, 2 * STEP);
		busy_len(1, n);
		chk(n, CONV);
		wr(A_CONFIG, 32'h60);
		wt(2);
		chk(sby, 1);
		chk(pwm, 0);
		wt(200);
		chk(busy, 0);
		ladc <= 8'h20;
		wt(200);
		rd(A_LOCAL_TEMP);
		chk(rdata, 0);
		wr(A_CONFIG, 32'h40);
		wt(2);
		chk(pwm, 1);
		print_verdict;
	end
endmodule // tla_core_tb
bind tla_core tla_core_asserts i_tla_core_asserts (.i_clk(i_clk), .i_rst(i_rst),
	.i_awvalid(i_awvalid), .i_wvalid(i_wvalid), .i_arvalid(i_arvalid), .i_bready(i_bready),
	.i_rready(i_rready), .o_awready(o_awready), .o_wready(o_wready), .o_arready(o_arready),
	.o_bvalid(o_bvalid), .o_rvalid(o_rvalid), .o_pwm_run(o_pwm_run), .o_standby(o_standby));
